// ### core/source_level_priority.sv
// Per-source level/priority control, masking and prioritisation for 62 request inputs.
// Assumes request inputs synchronous to CORE_CLK and a well-behaved AXI4-Lite master.
//
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns
`include "intc_consts.svh"

// Function
// - Each source holds level and priority entry
// - All entries readable; only 8 to 63 writable
// - Reset leaves every source disabled
// - Level bits 5:3, priority 2:0, 7:6 reserved
// - Priority 000 lowest, 111 highest
// - Fixed sources rank midpoint, priority reads 000
// - Edge flags 1-7, transfer-complete 9-12
// - Watchdog on 8, serial ports 13-15
// - 16 unused; bus, timer, ethernet on 17-35
// - Low voltage 36, converter flags 37-40
// - General timer A events on 41-47
// - Mask gates request; pending shows raw request
// - Acknowledge returns highest-priority vector in level, any level at base 0x120
module source_level_priority #(
	parameter int ADDR_W = 12,
	parameter logic [7:0] VECTOR_BASE = 8'h40
) (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic CE,
	input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic [6:0] EDGE_FLAGS,
	input wire logic WATCHDOG_TIMEOUT,
	input wire logic [3:0] DMA_DONE,
	input wire logic [2:0] SERIAL_IRQ,
	input wire logic TWO_WIRE_IRQ,
	input wire logic QSPI_IRQ,
	input wire logic [3:0] CAPTURE_TIMER,
	input wire logic [12:0] ETHERNET_IRQ,
	input wire logic LOW_VOLTAGE,
	input wire logic [3:0] CONVERTER_FLAGS,
	input wire logic [6:0] TIMER_A_FLAGS,
	input wire logic [15:0] UPPER_REQ,
	output logic [2:0] CORE_IPL,
	output logic [7:1] LEVEL_REQ
);

	// The map reaches 12'h13c, and base plus source 63 must not wrap past 8'hff
	if (ADDR_W < 9 || VECTOR_BASE > 8'hc0) begin : bad_params
		$error("source_level_priority: ADDR_W below 9 or VECTOR_BASE too large");
	end

	logic [63:0] req;
	logic [63:0][6:0] key;
	logic [63:0][5:0] ctrl;
	logic [63:0][5:0] next_ctrl;
	logic [63:0] mask;
	logic [63:0] next_mask;
	logic [63:0] pend;
	logic [7:0] ack_lp;
	logic [7:0] next_ack_lp;
	logic aw_held;
	logic next_aw_held;
	logic w_held;
	logic next_w_held;
	logic [ADDR_W-1:0] awaddr;
	logic [ADDR_W-1:0] next_awaddr;
	logic [31:0] wdata;
	logic [31:0] next_wdata;
	logic [3:0] wstrb;
	logic [3:0] next_wstrb;
	logic next_awready;
	logic next_wready;
	logic next_bvalid;
	logic [1:0] next_bresp;
	intc_pkg::rd_state_t rd_state;
	intc_pkg::rd_state_t next_rd_state;
	logic next_arready;
	logic next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;
	logic [2:0] next_ipl;
	logic [7:1] next_level_req;

	// Bit 16 has no source behind it; bit 0 is never a source
	assign req = {UPPER_REQ, TIMER_A_FLAGS, CONVERTER_FLAGS, LOW_VOLTAGE, ETHERNET_IRQ,
		CAPTURE_TIMER, QSPI_IRQ, TWO_WIRE_IRQ, 1'b0, SERIAL_IRQ, DMA_DONE,
		WATCHDOG_TIMEOUT, EDGE_FLAGS, 1'b0};

	// Programmed priorities take even ranks so the fixed midpoint can sit between 3 and 4
	function automatic logic [3:0] rank_of(input logic [2:0] prio);
		rank_of = {prio, 1'b0};
	endfunction

	function automatic logic [5:0] entry_of(input logic [ADDR_W-1:0] a);
		entry_of = 6'h00;
		if (a[1:0] == 2'h0 && a < ADDR_W'(`ENTRY_END)) begin
			entry_of = a[7:2];
		end
	endfunction

	// Highest key wins; on equal keys the lower source number is kept
	function automatic logic [12:0] pick(input logic [63:0][6:0] k, input logic [2:0] want);
		logic [6:0] best;
		logic [5:0] src;
		best = 7'h00;
		src = 6'h00;
		for (int i = 1; i < `SRC_COUNT; i++) begin
			if (k[i] != 7'h00 && (want == 3'h0 || k[i][6:4] == want) && k[i] > best) begin
				best = k[i];
				src = 6'(i);
			end
		end
		pick = {src, best};
	endfunction

	genvar g;
	generate
		assign key[0] = 7'h00;
		for (g = 1; g < `SRC_COUNT; g++) begin : src_keys
			logic [2:0] lvl;
			logic [3:0] rnk;
			assign lvl = (g < `SRC_FIRST_WRITABLE) ? 3'(g) : ctrl[g][`LEVEL_MSB:`LEVEL_LSB];
			assign rnk = (g < `SRC_FIRST_WRITABLE) ? `MID_RANK : rank_of(ctrl[g][`PRIO_MSB:`PRIO_LSB]);
			assign key[g] = (req[g] && !mask[g] && lvl != 3'h0) ? {lvl, rnk} : 7'h00;
		end
	endgenerate

	// Write path and writable registers
	always_comb begin
		logic [5:0] ent;
		ent = entry_of(awaddr);
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_awaddr = awaddr;
		next_wdata = wdata;
		next_wstrb = wstrb;
		next_bvalid = S_AXI_BVALID;
		next_bresp = S_AXI_BRESP;
		next_ctrl = ctrl;
		next_mask = mask;
		if (S_AXI_AWVALID && S_AXI_AWREADY) begin
			next_aw_held = 1'b1;
			next_awaddr = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && S_AXI_WREADY) begin
			next_w_held = 1'b1;
			next_wdata = S_AXI_WDATA;
			next_wstrb = S_AXI_WSTRB;
		end
		if (S_AXI_BVALID && S_AXI_BREADY) begin
			next_bvalid = 1'b0;
		end
		if (aw_held && w_held && !S_AXI_BVALID) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = `RESP_OKAY;
			if (ent != 6'h00) begin
				// Reserved bits 7:6 are not stored and read back as zero
				if (ent >= 6'(`SRC_FIRST_WRITABLE) && wstrb[0]) begin
					next_ctrl[ent] = wdata[5:0];
				end
			end else if (awaddr == ADDR_W'(`MASK_LOW_ADDR) || awaddr == ADDR_W'(`MASK_HIGH_ADDR)) begin
				for (int b = 0; b < 4; b++) begin
					if (wstrb[b]) begin
						next_mask[(awaddr[2] ? 32 : 0) + b * 8 +: 8] = wdata[b * 8 +: 8];
					end
				end
				// The mask-all bit forces every source mask on
				if (next_mask[0]) begin
					next_mask = `MASK_RESET;
				end
			end else if (awaddr < ADDR_W'(`PEND_LOW_ADDR) || awaddr >= ADDR_W'(`INTERRUPT_ACKNOWLEDGE_END_ADDR)
				|| awaddr[1:0] != 2'h0) begin
				next_bresp = `RESP_SLVERR;
			end
		end
		next_awready = !next_aw_held && !next_bvalid;
		next_wready = !next_w_held && !next_bvalid;
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			awaddr <= '0;
			wdata <= 32'h00000000;
			wstrb <= 4'h0;
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY <= 1'b0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= `RESP_OKAY;
			ctrl <= '0;
			mask <= `MASK_RESET;
		end else if (CE) begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			awaddr <= next_awaddr;
			wdata <= next_wdata;
			wstrb <= next_wstrb;
			S_AXI_AWREADY <= next_awready;
			S_AXI_WREADY <= next_wready;
			S_AXI_BVALID <= next_bvalid;
			S_AXI_BRESP <= next_bresp;
			ctrl <= next_ctrl;
			mask <= next_mask;
		end
	end

	// Read path; an acknowledge read also loads the level/priority capture
	always_comb begin
		logic [5:0] ent;
		logic [12:0] sel;
		ent = entry_of(S_AXI_ARADDR);
		sel = pick(key, S_AXI_ARADDR[4:2]);
		next_rd_state = rd_state;
		next_rvalid = S_AXI_RVALID;
		next_rdata = S_AXI_RDATA;
		next_rresp = S_AXI_RRESP;
		next_ack_lp = ack_lp;
		case (rd_state)
			intc_pkg::RD_IDLE: begin
				if (S_AXI_ARVALID && S_AXI_ARREADY) begin
					next_rd_state = intc_pkg::RD_RESP;
					next_rvalid = 1'b1;
					next_rresp = `RESP_OKAY;
					next_rdata = 32'h00000000;
					if (ent != 6'h00) begin
						if (ent < 6'(`SRC_FIRST_WRITABLE)) begin
							next_rdata[5:0] = {ent[2:0], 3'h0};
						end else begin
							next_rdata[5:0] = ctrl[ent];
						end
					end else if (S_AXI_ARADDR[1:0] != 2'h0) begin
						next_rresp = `RESP_SLVERR;
					end else if (S_AXI_ARADDR == ADDR_W'(`MASK_LOW_ADDR)) begin
						next_rdata = mask[31:0];
					end else if (S_AXI_ARADDR == ADDR_W'(`MASK_HIGH_ADDR)) begin
						next_rdata = mask[63:32];
					end else if (S_AXI_ARADDR == ADDR_W'(`PEND_LOW_ADDR)) begin
						next_rdata = pend[31:0];
					end else if (S_AXI_ARADDR == ADDR_W'(`PEND_HIGH_ADDR)) begin
						next_rdata = pend[63:32];
					end else if (S_AXI_ARADDR == ADDR_W'(`LEVEL_REQ_ADDR)) begin
						next_rdata[7:0] = {LEVEL_REQ, 1'b0};
					end else if (S_AXI_ARADDR == ADDR_W'(`ACK_LP_ADDR)) begin
						next_rdata[7:0] = ack_lp;
					end else if (S_AXI_ARADDR >= ADDR_W'(`INTERRUPT_ACKNOWLEDGE_BASE_ADDR) && S_AXI_ARADDR < ADDR_W'(`INTERRUPT_ACKNOWLEDGE_END_ADDR)) begin
						// No active source gives a zero vector and clears the capture
						next_ack_lp = 8'h00;
						if (sel[6:0] != 7'h00) begin
							next_rdata[7:0] = VECTOR_BASE + {2'h0, sel[12:7]};
							next_ack_lp[6:4] = sel[6:4];
							next_ack_lp[3:0] = (sel[3:0] == `MID_RANK) ? `MID_PRIO_CODE : {1'b0, sel[3:1]};
						end
					end else begin
						next_rresp = `RESP_SLVERR;
					end
				end
			end
			intc_pkg::RD_RESP: begin
				if (S_AXI_RREADY) begin
					next_rd_state = intc_pkg::RD_IDLE;
					next_rvalid = 1'b0;
				end
			end
			default: begin
				next_rd_state = intc_pkg::RD_IDLE;
				next_rvalid = 1'b0;
			end
		endcase
		next_arready = (next_rd_state == intc_pkg::RD_IDLE);
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			rd_state <= intc_pkg::RD_IDLE;
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h00000000;
			S_AXI_RRESP <= `RESP_OKAY;
			ack_lp <= 8'h00;
		end else if (CE) begin
			rd_state <= next_rd_state;
			S_AXI_ARREADY <= next_arready;
			S_AXI_RVALID <= next_rvalid;
			S_AXI_RDATA <= next_rdata;
			S_AXI_RRESP <= next_rresp;
			ack_lp <= next_ack_lp;
		end
	end

	// Level request towards the core; one cycle of latency buys registered outputs
	always_comb begin
		logic [12:0] top;
		top = pick(key, 3'h0);
		next_level_req = 7'h00;
		for (int i = 1; i < `SRC_COUNT; i++) begin
			if (key[i] != 7'h00) begin
				next_level_req[key[i][6:4]] = 1'b1;
			end
		end
		next_ipl = top[6:4];
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			CORE_IPL <= 3'h0;
			LEVEL_REQ <= 7'h00;
			pend <= 64'h0000000000000000;
		end else if (CE) begin
			CORE_IPL <= next_ipl;
			LEVEL_REQ <= next_level_req;
			pend <= req;
		end
	end

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST || !CE);

	sequence wr_commit;
		aw_held && w_held && !S_AXI_BVALID;
	endsequence

	sequence wr_entry8;
		wr_commit and (entry_of(awaddr) >= 6'h08) and wstrb[0];
	endsequence

	reset_disabled_a: assert property ($fell(RST) |-> ctrl == '0 && mask == `MASK_RESET && CORE_IPL == 3'h0)
		else $error("entries not cleared after reset");

	entry_write_a: assert property (wr_entry8 |=> ctrl[$past(awaddr[7:2])] == $past(wdata[5:0]))
		else $error("writable entry did not take written value");

	fixed_ro_a: assert property (wr_commit and entry_of(awaddr) != 6'h00 and entry_of(awaddr) < 6'h08
		|=> ctrl == $past(ctrl))
		else $error("fixed entry changed by write");

	fixed_read_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY && entry_of(S_AXI_ARADDR) != 6'h00
		&& entry_of(S_AXI_ARADDR) < 6'h08 |=> S_AXI_RVALID && S_AXI_RDATA[2:0] == 3'h0
		&& S_AXI_RDATA[5:3] == $past(S_AXI_ARADDR[4:2]) && S_AXI_RDATA[7:6] == 2'h0)
		else $error("fixed entry read wrong");

	level_zero_a: assert property (ctrl[8][5:3] == 3'h0 |-> key[8] == 7'h00)
		else $error("level zero source contributes");

	mask_gate_a: assert property (mask[9] |-> key[9] == 7'h00 ##1 pend[9] == $past(req[9]))
		else $error("masked source not gated or pending wrong");

	prio_order_a: assert property (req[8] && req[10] && !mask[8] && !mask[10] && ctrl[8][5:3] != 3'h0
		&& ctrl[8][5:3] == ctrl[10][5:3] && ctrl[8][2:0] == 3'h7 && ctrl[10][2:0] == 3'h0
		|-> (key[8] > key[10]) ##1 (CORE_IPL >= $past(ctrl[8][5:3])))
		else $error("priority ordering wrong");

	ipl_top_a: assert property (CORE_IPL != 3'h0 |-> LEVEL_REQ[CORE_IPL]
		&& (LEVEL_REQ >> CORE_IPL) == 7'h00)
		else $error("core level is not the highest requesting level");

	ack_level_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR >= ADDR_W'(`INTERRUPT_ACKNOWLEDGE_BASE_ADDR) + 4
		&& S_AXI_ARADDR < ADDR_W'(`INTERRUPT_ACKNOWLEDGE_END_ADDR) && S_AXI_ARADDR[1:0] == 2'h0
		|=> S_AXI_RVALID && (ack_lp == 8'h00 || ack_lp[6:4] == $past(S_AXI_ARADDR[4:2])))
		else $error("acknowledge returned a source of another level");

	unused_src_a: assert property (##1 pend[`SRC_UNUSED] == 1'b0 && pend[12:9] == $past(DMA_DONE))
		else $error("source mapping wrong");

	bresp_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
		else $error("write response dropped before taken");

endmodule

// ### core/intc_consts.svh
// Offsets, field positions, reset values and counts for the source level/priority block.
// Assumes a 32-bit AXI4-Lite slave where each register takes one aligned word.
`ifndef INTC_CONSTS_SVH
`define INTC_CONSTS_SVH

// Entry n sits at byte address 4*n, n = 1..63; address 0 is unmapped
`define ENTRY_END 12'h100
`define MASK_LOW_ADDR 12'h100
`define MASK_HIGH_ADDR 12'h104
`define PEND_LOW_ADDR 12'h108
`define PEND_HIGH_ADDR 12'h10c
`define LEVEL_REQ_ADDR 12'h110
`define ACK_LP_ADDR 12'h114
`define INTERRUPT_ACKNOWLEDGE_BASE_ADDR 12'h120
`define INTERRUPT_ACKNOWLEDGE_END_ADDR 12'h140

// Entry layout
`define LEVEL_MSB 5
`define LEVEL_LSB 3
`define PRIO_MSB 2
`define PRIO_LSB 0
`define ENTRY_RESET 6'h00

// Sources below this number have a fixed level equal to their number
`define SRC_FIRST_WRITABLE 8
`define SRC_UNUSED 16
`define SRC_COUNT 64

// Rank of a fixed-level source: between programmed priorities 3 and 4
`define MID_RANK 4'h7
`define MID_PRIO_CODE 4'h8

`define MASK_RESET 64'hffffffffffffffff
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### core/intc_pkg.sv
// Types shared by the source level/priority block.
// Assumes nothing beyond a SystemVerilog compiler.
package intc_pkg;
	typedef enum logic [0:0] {
		RD_IDLE = 1'b0,
		RD_RESP = 1'b1
	} rd_state_t;
	typedef logic [5:0] ctrl_entry_t;
	typedef logic [6:0] src_key_t;
endpackage

// ### testbench/intc_req_model.sv
// Peripheral side: spreads a vector of held request levels onto the per-peripheral request ports.
// Assumes the bench changes the vector right after a rising clock edge.
`timescale 1ns/1ns
module intc_req_model (
	input wire logic [63:0] req,
	output logic [6:0] edge_flags,
	output logic watchdog,
	output logic [3:0] dma_done,
	output logic [2:0] serial_irq,
	output logic two_wire,
	output logic qspi,
	output logic [3:0] capture,
	output logic [12:0] ethernet,
	output logic low_voltage,
	output logic [3:0] converter,
	output logic [6:0] timer_a,
	output logic [15:0] upper
);
	// Requests stay high until the bench clears them, as a serviced peripheral would
	assign edge_flags = req[7:1];
	assign watchdog = req[8];
	assign dma_done = req[12:9];
	assign serial_irq = req[15:13];
	// Bit 16 has no peripheral behind it
	assign two_wire = req[17];
	assign qspi = req[18];
	assign capture = req[22:19];
	assign ethernet = req[35:23];
	assign low_voltage = req[36];
	assign converter = req[40:37];
	assign timer_a = req[47:41];
	assign upper = req[63:48];
endmodule

// ### testbench/tb_top.sv
// Self-checking bench for the source level/priority block.
// Assumes the design files are compiled first and the include path holds core/.
`timescale 1ns/1ns
module tb_top;
	logic clk = 1'b0, rst = 1'b1, ce = 1'b1;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h00000000, rdata;
	logic [3:0] wstrb = 4'h0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, r;
	logic [63:0] req = 64'h0;
	logic [6:0] ef, ta;
	logic [3:0] dd, ct, cv;
	logic [2:0] si, ipl;
	logic [12:0] eth;
	logic [15:0] up;
	logic wd, tw, qs, lv;
	logic [7:1] lreq;
	logic [31:0] d, lo;
	int n_errors = 0, n_checks = 0, cycles = 0;
	always #25 clk = ~clk;
	intc_req_model model (.req(req), .edge_flags(ef), .watchdog(wd), .dma_done(dd), .serial_irq(si),
		.two_wire(tw), .qspi(qs), .capture(ct), .ethernet(eth), .low_voltage(lv), .converter(cv),
		.timer_a(ta), .upper(up));
	source_level_priority uut (.CORE_CLK(clk), .RST(rst), .CE(ce), .S_AXI_AWADDR(awaddr),
		.S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
		.S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
		.S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.EDGE_FLAGS(ef), .WATCHDOG_TIMEOUT(wd), .DMA_DONE(dd), .SERIAL_IRQ(si), .TWO_WIRE_IRQ(tw),
		.QSPI_IRQ(qs), .CAPTURE_TIMER(ct), .ETHERNET_IRQ(eth), .LOW_VOLTAGE(lv), .CONVERTER_FLAGS(cv),
		.TIMER_A_FLAGS(ta), .UPPER_REQ(up), .CORE_IPL(ipl), .LEVEL_REQ(lreq));
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("Checks %0d, mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// A hang in any handshake ends here rather than in the simulator's own limit
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			final_report();
		end
	end
	task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] resp);
		logic aw_done, w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge clk);
		awaddr <= a; awvalid <= 1'b1; wdata <= v; wstrb <= 4'hf; wvalid <= 1'b1; bready <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge clk);
			if (!aw_done && awready === 1'b1) begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_done && wready === 1'b1) begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clk); while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] resp);
		@(posedge clk);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk); while (rvalid !== 1'b1);
		v = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask
	task automatic drive_req(input logic [63:0] v);
		@(posedge clk);
		req <= v;
		repeat (3) @(posedge clk);
	endtask
	task automatic t_regs();
		for (int n = 1; n < 8; n++) begin
			rd(12'(n * 4), d, r);
			check(d, 64'(n << 3));
		end
		rd(12'h020, d, r);
		check(d, 64'h0);
		rd(12'h0fc, d, r);
		check(d, 64'h0);
		rd(12'h100, d, r);
		check(d, 64'hffffffff);
		check(ipl, 64'h0);
		wr(12'h00c, 32'h0000003f, r);
		check(r, 64'h0);
		rd(12'h00c, d, r);
		check(d, 64'h18);
		wr(12'h0fc, 32'h000000ff, r);
		rd(12'h0fc, d, r);
		check(d, 64'h3f);
		wr(12'h000, 32'h00000001, r);
		check(r, 64'h2);
		rd(12'h002, d, r);
		check(r, 64'h2);
		$display("Test registers done");
	endtask
	// Every source is raised alone, still masked, and must show at its own pending bit
	task automatic t_map();
		for (int s = 1; s < 64; s++) begin
			drive_req(64'h1 << s);
			rd(12'h108, lo, r);
			rd(12'h10c, d, r);
			check({d, lo}, (s == 16) ? 64'h0 : (64'h1 << s));
			check(ipl, 64'h0);
		end
		$display("Test source map done");
	endtask
	task automatic t_prio();
		wr(12'h100, 32'h0, r);
		wr(12'h104, 32'h0, r);
		wr(12'h050, 32'h0000002a, r);
		wr(12'h078, 32'h0000002e, r);
		wr(12'h0a0, 32'h00000019, r);
		drive_req((64'h1 << 20) | (64'h1 << 30) | (64'h1 << 40) | (64'h1 << 50));
		check(ipl, 64'h5);
		check(lreq, 64'h14);
		rd(12'h120, d, r);
		check(d, 64'h5e);
		rd(12'h114, d, r);
		check(d, 64'h56);
		rd(12'h12c, d, r);
		check(d, 64'h68);
		rd(12'h13c, d, r);
		check(d, 64'h0);
		wr(12'h100, 32'h40000000, r);
		rd(12'h120, d, r);
		check(d, 64'h54);
		rd(12'h108, d, r);
		check(d, 64'h40100000);
		wr(12'h100, 32'h0, r);
		drive_req((64'h1 << 5) | (64'h1 << 20) | (64'h1 << 30));
		rd(12'h134, d, r);
		check(d, 64'h5e);
		drive_req((64'h1 << 5) | (64'h1 << 20));
		rd(12'h134, d, r);
		check(d, 64'h45);
		rd(12'h114, d, r);
		check(d, 64'h58);
		drive_req(64'h1 << 50);
		check(ipl, 64'h0);
		check(lreq, 64'h0);
		rd(12'h120, d, r);
		check(d, 64'h0);
		// Same level, extreme codes: priority 111 must beat priority 000
		wr(12'h020, 32'h00000037, r);
		wr(12'h028, 32'h00000030, r);
		drive_req((64'h1 << 8) | (64'h1 << 10));
		check(ipl, 64'h6);
		rd(12'h138, d, r);
		check(d, 64'h48);
		rd(12'h114, d, r);
		check(d, 64'h67);
		wr(12'h100, 32'h00000001, r);
		rd(12'h104, d, r);
		check(d, 64'hffffffff);
		drive_req(64'h1 << 20);
		check(ipl, 64'h0);
		$display("Test priority done");
	endtask
	// Clock enable low must hold the outputs although the requests change under it
	task automatic t_freeze();
		wr(12'h100, 32'h00000000, r);
		@(posedge clk);
		check(ipl, 64'h5);
		ce <= 1'b0;
		req <= 64'h0;
		repeat (3) @(posedge clk);
		check(ipl, 64'h5);
		check(lreq, 64'h10);
		ce <= 1'b1;
		repeat (2) @(posedge clk);
		check(ipl, 64'h0);
		$display("Test clock enable done");
	endtask
	// A reset in mid-run must clear entries and capture and set the low mask word with a request still standing
	task automatic t_reset();
		@(posedge clk);
		req <= 64'h1 << 20;
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd(12'h050, d, r);
		check(d, 64'h0);
		rd(12'h100, d, r);
		check(d, 64'hffffffff);
		rd(12'h114, d, r);
		check(d, 64'h0);
		check(ipl, 64'h0);
		$display("Test reset done");
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_map();
		t_prio();
		t_freeze();
		t_reset();
		final_report();
	end
endmodule
